// ===== inc/adcsc_pkg.sv
package adcsc_pkg;

	// Clock rates.
	localparam int unsigned SYS_CLK_HZ = 10_000_000;
	localparam int unsigned OSC_HZ     = 307_200;
	localparam int unsigned ISCK_HZ    = OSC_HZ / 8;
	localparam int unsigned EXT_MIN_HZ = 10_000;

	// Cycle counts derived from the rates.
	localparam int unsigned OSC_DIV     = SYS_CLK_HZ / OSC_HZ;
	localparam int unsigned ISCK_HALF   = SYS_CLK_HZ / (2 * ISCK_HZ);
	localparam int unsigned EXT_TIMEOUT = 2 * (SYS_CLK_HZ / EXT_MIN_HZ);

	// Conversion length in conversion clock periods.
	localparam int unsigned CONV_TICKS_1X = 41036;
	localparam int unsigned CONV_TICKS_2X = 20556;

	// Frame and configuration word layout.
	localparam logic [4:0] FRAME_LAST  = 5'h16;
	localparam logic [4:0] FRAME_BITS  = 5'h18;
	localparam logic [4:0] CFG_BITS    = 5'h08;
	localparam logic [5:0] ISCK_EDGES  = 6'h31;
	localparam int unsigned CFG_EN_POS = 7;
	localparam int unsigned CFG_GS_HI  = 6;
	localparam int unsigned CFG_GS_LO  = 4;
	localparam int unsigned CFG_TEMP   = 3;
	localparam int unsigned CFG_REJ_HI = 2;
	localparam int unsigned CFG_REJ_LO = 1;
	localparam int unsigned CFG_DBL    = 0;

	// Values after reset: external input, gain 1, 50/60 Hz, normal speed.
	localparam logic [2:0] GAIN_RST     = 3'h0;
	localparam logic       TEMP_RST     = 1'b0;
	localparam logic [1:0] REJ_RST      = 2'h0;
	localparam logic       DBL_RST      = 1'b0;
	localparam logic [1:0] REJ_RESERVED = 2'h3;
	localparam logic [8:0] GAIN_UNITY   = 9'h001;

	typedef enum logic [1:0] {
		ST_CONV,
		ST_SLEEP,
		ST_OUTPUT
	} adcsc_state_t;

	// Gain factor from the three select bits and the speed mode.
	function automatic logic [8:0] adcsc_gain(input logic [2:0] code, input logic dbl);
		logic [3:0] sh;
		sh = {1'b0, code};
		if (!dbl && code != 3'h0) begin
			sh = sh + 4'h1;
		end
		return GAIN_UNITY << sh;
	endfunction

endpackage

// ===== hw/adcsc_core.sv
`timescale 1ns/10ps
module adcsc_core #(
	parameter int unsigned CONV_TICKS_1X = adcsc_pkg::CONV_TICKS_1X,
	parameter int unsigned CONV_TICKS_2X = adcsc_pkg::CONV_TICKS_2X
) (
	// System clock and reset.
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// Serial interface pins.
	input  wire logic       cs_n,
	input  wire logic       sdi,
	input  wire logic       sck_clk,
	output logic            sck_out,
	output logic            sck_oe,
	output logic            sck_pullup_en,
	output logic            sdo_out,
	output logic            sdo_oe,
	// Conversion clock pin.
	input  wire logic       conv_clock_pin,
	// Converter datapath.
	input  wire logic [17:0] conv_data,
	output logic            conv_active,
	output logic            sleep_active,
	output logic            conv_done,
	output logic            conv_clock_ext,
	output logic [8:0]      gain_factor,
	output logic            temp_input_select,
	output logic            reject_select_a,
	output logic            reject_select_b,
	output logic            double_rate_select,
	output logic            autocal_en
);
	import adcsc_pkg::*;

	adcsc_state_t state_q;
	logic cs_s1_q, cs_s2_q, cs_prev_q;
	logic sck_s1_q, sck_s2_q;
	logic cc_s1_q, cc_s2_q, cc_prev_q;
	logic rise_s1_q, rise_s2_q;
	logic done_s1_q, done_s2_q;
	logic full_s1_q, full_s2_q;
	logic [1:0] init_q;
	logic [5:0] osc_cnt_q;
	logic [11:0] ext_tmr_q;
	logic ext_q, tick;
	logic [15:0] conv_cnt_q, conv_len;
	logic [23:0] frame_q;
	logic [2:0] cfg_gain_q, run_gain_q;
	logic cfg_temp_q, run_temp_q, cfg_dbl_q, run_dbl_q;
	logic [1:0] cfg_rej_q, run_rej_q;
	logic link_clr_q, out_sel_q, eoc_q, int_mode_q, load_q;
	logic [7:0] div_q;
	logic [5:0] isck_cnt_q;
	logic [4:0] rise_cnt_q, fall_cnt_q;
	logic [7:0] cfg_sh_q;
	logic rise_seen_q, cfg_full_q, frame_done_q, sdo_bit_q;
	logic leave_out, conv_end;

	// Chip select, serial clock and conversion clock pins pass two flip-flops.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_prev_q <= 1'b1;
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			cc_s1_q <= 1'b0;
			cc_s2_q <= 1'b0;
			cc_prev_q <= 1'b0;
		end else begin
			cs_s1_q <= cs_n;
			cs_s2_q <= cs_s1_q;
			cs_prev_q <= cs_s2_q;
			sck_s1_q <= sck_clk;
			sck_s2_q <= sck_s1_q;
			cc_s1_q <= conv_clock_pin;
			cc_s2_q <= cc_s1_q;
			cc_prev_q <= cc_s2_q;
		end
	end

	// Flags from the link domain.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rise_s1_q <= 1'b0;
			rise_s2_q <= 1'b0;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			full_s1_q <= 1'b0;
			full_s2_q <= 1'b0;
		end else begin
			rise_s1_q <= rise_seen_q;
			rise_s2_q <= rise_s1_q;
			done_s1_q <= frame_done_q;
			done_s2_q <= done_s1_q;
			full_s1_q <= cfg_full_q;
			full_s2_q <= full_s1_q;
		end
	end

	// Clock mode taken once the pin level has crossed the synchroniser, and at each chip select fall.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			init_q <= 2'h0;
			int_mode_q <= 1'b0;
		end else begin
			init_q <= init_q + {1'b0, init_q != 2'h3};
			if (init_q == 2'h2 || (cs_prev_q && !cs_s2_q)) begin
				int_mode_q <= sck_s2_q;
			end
		end
	end

	// Conversion clock: pin edges while present, else internal divider.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			osc_cnt_q <= 6'h00;
			ext_tmr_q <= 12'h000;
			ext_q <= 1'b0;
		end else begin
			if (osc_cnt_q == 6'(OSC_DIV - 1)) begin
				osc_cnt_q <= 6'h00;
			end else begin
				osc_cnt_q <= osc_cnt_q + 6'h01;
			end
			if (cc_s2_q && !cc_prev_q) begin
				ext_tmr_q <= 12'h000;
				ext_q <= 1'b1;
			end else if (ext_tmr_q == 12'(EXT_TIMEOUT)) begin
				ext_q <= 1'b0;
			end else begin
				ext_tmr_q <= ext_tmr_q + 12'h001;
			end
		end
	end

	always_comb begin
		if (ext_q) begin
			tick = cc_s2_q && !cc_prev_q;
		end else begin
			tick = osc_cnt_q == 6'(OSC_DIV - 1);
		end
	end

	// Double rate halves the conversion.
	assign conv_len = run_dbl_q ? 16'(CONV_TICKS_2X) : 16'(CONV_TICKS_1X);
	assign conv_end = state_q == ST_CONV && tick && conv_cnt_q == conv_len - 16'h0001;
	assign leave_out = state_q == ST_OUTPUT && (cs_s2_q || done_s2_q);

	// Conversion, sleep and output states.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_CONV;
			conv_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_CONV: begin
					if (conv_end) begin
						state_q <= ST_SLEEP;
						conv_cnt_q <= 16'h0000;
					end else if (tick) begin
						conv_cnt_q <= conv_cnt_q + 16'h0001;
					end
				end
				ST_SLEEP: begin
					if (!cs_s2_q) begin
						state_q <= ST_OUTPUT;
					end
				end
				default: begin
					if (done_s2_q || (cs_s2_q && rise_s2_q)) begin
						state_q <= ST_CONV;
					end else if (cs_s2_q) begin
						state_q <= ST_SLEEP;
					end
				end
			endcase
		end
	end

	// Result held static from conversion end until the next one.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			frame_q <= 24'h000000;
		end else if (conv_end) begin
			frame_q <= {1'b0, 1'b0, conv_data, run_gain_q, run_temp_q};
		end
	end

	// Configuration word applied when the output state ends.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cfg_gain_q <= GAIN_RST;
			cfg_temp_q <= TEMP_RST;
			cfg_rej_q <= REJ_RST;
			cfg_dbl_q <= DBL_RST;
		end else if (leave_out && (done_s2_q || rise_s2_q) && full_s2_q && cfg_sh_q[CFG_EN_POS]) begin
			cfg_gain_q <= cfg_sh_q[CFG_GS_HI:CFG_GS_LO];
			cfg_temp_q <= cfg_sh_q[CFG_TEMP];
			cfg_dbl_q <= cfg_sh_q[CFG_DBL];
			if (cfg_sh_q[CFG_REJ_HI:CFG_REJ_LO] != REJ_RESERVED) begin
				cfg_rej_q <= cfg_sh_q[CFG_REJ_HI:CFG_REJ_LO];
			end
		end
	end

	// Settings in force for the running conversion, loaded the cycle after a new word lands.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			run_gain_q <= GAIN_RST;
			run_temp_q <= TEMP_RST;
			run_rej_q <= REJ_RST;
			run_dbl_q <= DBL_RST;
			gain_factor <= GAIN_UNITY;
		end else if (load_q) begin
			run_temp_q <= cfg_temp_q;
			run_rej_q <= cfg_rej_q;
			if (cfg_temp_q) begin
				run_gain_q <= GAIN_RST;
				run_dbl_q <= DBL_RST;
				gain_factor <= GAIN_UNITY;
			end else begin
				run_gain_q <= cfg_gain_q;
				run_dbl_q <= cfg_dbl_q;
				gain_factor <= adcsc_gain(cfg_gain_q, cfg_dbl_q);
			end
		end
	end

	// Mode outputs and status.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			temp_input_select <= TEMP_RST;
			reject_select_a <= REJ_RST[1];
			reject_select_b <= REJ_RST[0];
			double_rate_select <= DBL_RST;
			autocal_en <= 1'b1;
			conv_active <= 1'b1;
			sleep_active <= 1'b0;
			conv_done <= 1'b0;
			conv_clock_ext <= 1'b0;
			eoc_q <= 1'b1;
		end else begin
			temp_input_select <= run_temp_q;
			reject_select_a <= run_rej_q[1];
			reject_select_b <= run_rej_q[0];
			double_rate_select <= run_dbl_q;
			autocal_en <= !run_dbl_q;
			conv_active <= state_q == ST_CONV && !conv_end;
			sleep_active <= state_q == ST_SLEEP && cs_s2_q;
			conv_done <= conv_end;
			conv_clock_ext <= ext_q;
			eoc_q <= state_q == ST_CONV && !conv_end;
		end
	end

	// Pin drivers and link domain clear.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			link_clr_q <= 1'b1;
			load_q <= 1'b0;
			out_sel_q <= 1'b0;
			sdo_oe <= 1'b0;
			sck_pullup_en <= 1'b0;
		end else begin
			link_clr_q <= state_q != ST_OUTPUT || leave_out;
			load_q <= leave_out;
			out_sel_q <= state_q == ST_OUTPUT && !leave_out;
			sdo_oe <= !cs_s2_q;
			sck_pullup_en <= int_mode_q;
		end
	end

	// Status bit outside output state, shifted data within it.
	assign sdo_out = out_sel_q ? sdo_bit_q : eoc_q;

	// Internal serial clock: idles high, one lead-in fall, then 24 pulses per readout.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_q <= 8'h00;
			isck_cnt_q <= 6'h00;
			sck_out <= 1'b1;
			sck_oe <= 1'b0;
		end else if (int_mode_q && state_q == ST_OUTPUT && !cs_s2_q) begin
			sck_oe <= 1'b1;
			if (isck_cnt_q != ISCK_EDGES) begin
				if (div_q == 8'(ISCK_HALF - 1)) begin
					div_q <= 8'h00;
					sck_out <= !sck_out;
					isck_cnt_q <= isck_cnt_q + 6'h01;
				end else begin
					div_q <= div_q + 8'h01;
				end
			end
		end else begin
			div_q <= 8'h00;
			isck_cnt_q <= 6'h00;
			sck_out <= 1'b1;
			sck_oe <= 1'b0;
		end
	end

	// Link domain, rising edges: count and capture configuration.
	always_ff @(posedge sck_clk or posedge link_clr_q) begin
		if (link_clr_q) begin
			rise_cnt_q <= 5'h00;
			cfg_sh_q <= 8'h00;
			rise_seen_q <= 1'b0;
			cfg_full_q <= 1'b0;
		end else begin
			rise_seen_q <= 1'b1;
			if (rise_cnt_q != CFG_BITS) begin
				cfg_sh_q <= {cfg_sh_q[6:0], sdi};
				rise_cnt_q <= rise_cnt_q + 5'h01;
			end
			cfg_full_q <= rise_cnt_q >= CFG_BITS - 5'h01;
		end
	end

	// Link domain, falling edges after the first rise: next frame bit, ones past the end.
	always_ff @(negedge sck_clk or posedge link_clr_q) begin
		if (link_clr_q) begin
			fall_cnt_q <= 5'h00;
			sdo_bit_q <= 1'b0;
			frame_done_q <= 1'b0;
		end else if (rise_seen_q) begin
			if (fall_cnt_q <= FRAME_LAST) begin
				sdo_bit_q <= frame_q[FRAME_LAST - fall_cnt_q];
			end else begin
				sdo_bit_q <= 1'b1;
			end
			if (fall_cnt_q != FRAME_BITS) begin
				fall_cnt_q <= fall_cnt_q + 5'h01;
			end
			frame_done_q <= fall_cnt_q >= FRAME_BITS - 5'h01;
		end
	end

	chk_hiz_when_high: assert property (@(posedge sys_clk) disable iff (reset)
		cs_s2_q |=> !sdo_oe) else $error("data output driven while chip select high");
	chk_wake_to_out: assert property (@(posedge sys_clk) disable iff (reset)
		state_q == ST_SLEEP && !cs_s2_q |=> state_q == ST_OUTPUT) else $error("no wake on select");

	chk_sleep_hold: assert property (@(posedge sys_clk) disable iff (reset)
		state_q == ST_SLEEP && cs_s2_q |=> state_q == ST_SLEEP && $stable(frame_q))
		else $error("sleep left or result lost");

	chk_abort_restart: assert property (@(posedge sys_clk) disable iff (reset)
		state_q == ST_OUTPUT && cs_s2_q && rise_s2_q |=> state_q == ST_CONV ##1 eoc_q)
		else $error("abort did not restart conversion");

	chk_early_return: assert property (@(posedge sys_clk) disable iff (reset)
		state_q == ST_OUTPUT && cs_s2_q && !rise_s2_q && !done_s2_q |=> state_q == ST_SLEEP)
		else $error("early select rise did not return to sleep");

	chk_cycle_order: assert property (@(posedge sys_clk) disable iff (reset)
		state_q == ST_SLEEP && $past(state_q) != ST_SLEEP |-> $past(state_q) != ST_CONV || $past(conv_end))
		else $error("sleep entered out of order");

	chk_temp_force: assert property (@(posedge sys_clk) disable iff (reset)
		run_temp_q |-> gain_factor == GAIN_UNITY && !run_dbl_q) else $error("temperature input not forced");
	chk_gain_top: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(state_q == ST_CONV) && !run_temp_q && run_gain_q == 3'h7 |-> gain_factor == (run_dbl_q ? 9'h080 : 9'h100))
		else $error("gain map wrong");

	chk_status_bit: assert property (@(posedge sys_clk) disable iff (reset)
		state_q == ST_CONV && $past(state_q) == ST_CONV && !out_sel_q |-> sdo_out)
		else $error("status not shown during conversion");

	chk_isck_mode: assert property (@(posedge sys_clk) disable iff (reset)
		sck_oe |-> int_mode_q && sck_pullup_en) else $error("clock driven in external mode");

endmodule

// ===== test/adcsc_host.sv
`timescale 1ns/10ps
module adcsc_host (
	// Pacing clock.
	input  wire logic sys_clk,
	// Pins towards the converter.
	output logic      cs_n,
	output logic      sdi,
	output logic      sck,
	// Data line as the host sees it.
	input  wire logic sdo
);
	initial begin
		cs_n = 1'b1;
		sdi  = 1'b0;
		sck  = 1'b0;
	end
	// Moves chip select just after a falling system clock edge.
	task automatic sel(input logic v);
		@(negedge sys_clk);
		cs_n = v;
	endtask
	// Sets the resting level of the clock pin, which picks the clock mode.
	task automatic idle(input logic v);
		@(negedge sys_clk);
		sck = v;
	endtask
	// Clocks n bits, sending the word first and reading the frame; the clock then stands still.
	task automatic xfer(input logic [7:0] w, input int n, output logic [23:0] rx);
		rx = 24'h0;
		for (int i = 0; i < n; i++) begin
			sdi = (i < 8) ? w[7 - i] : 1'b0;
			#16 sck = 1'b1;
			rx[23 - i] = sdo;
			#16 sck = 1'b0;
		end
	endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
	logic        sys_clk;
	logic        reset;
	logic        tog            = 1'b0;
	logic        conv_clock_pin;
	logic [17:0] conv_data;
	logic [23:0] isk_rx;
	logic [17:0] res            = 18'h0;
	logic [6:0]  cur            = 7'h00;
	wire         cs_n, sdi, h_sck, sck_out, sck_oe, sck_pullup_en, sdo_out, sdo_oe;
	wire         conv_active, sleep_active, conv_done, conv_clock_ext, autocal_en;
	wire         temp_input_select, reject_select_a, reject_select_b, double_rate_select;
	wire [8:0]   gain_factor;
	wire         sck_line = sck_oe ? sck_out : h_sck;
	wire         sdo_line = sdo_oe ? sdo_out : tog;
	int          fails    = 0;
	int          n_tests  = 0;

	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) tog <= ~tog;
	always @(posedge sck_line) if (sck_oe) isk_rx <= {isk_rx[22:0], sdo_line};

	adcsc_core #(.CONV_TICKS_1X(20), .CONV_TICKS_2X(10)) i_adcsc_core (
		.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .sdi(sdi), .sck_clk(sck_line),
		.sck_out(sck_out), .sck_oe(sck_oe), .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .conv_clock_pin(conv_clock_pin), .conv_data(conv_data),
		.conv_active(conv_active), .sleep_active(sleep_active), .conv_done(conv_done),
		.conv_clock_ext(conv_clock_ext), .gain_factor(gain_factor),
		.temp_input_select(temp_input_select), .reject_select_a(reject_select_a),
		.reject_select_b(reject_select_b), .double_rate_select(double_rate_select),
		.autocal_en(autocal_en));
	adcsc_host i_adcsc_host (.sys_clk(sys_clk), .cs_n(cs_n), .sdi(sdi), .sck(h_sck), .sdo(sdo_line));

	task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Compares the mode outputs with the mode kept by the bench.
	task automatic mode_chk();
		logic       d;
		logic [8:0] g;
		d = cur[0] & ~cur[3];
		g = cur[3] ? 9'h001 : 9'h001 << ({1'b0, cur[6:4]} + {3'h0, ~d && cur[6:4] != 3'h0});
		check("mode", {gain_factor, temp_input_select, reject_select_a, reject_select_b,
			double_rate_select, autocal_en}, {g, cur[3], cur[2:1], d, ~d});
	endtask
	// Waits for the conversion end and notes the stored result.
	task automatic wait_done(output int k);
		for (k = 0; k < 3000 && conv_done !== 1'b1; k++) @(negedge sys_clk);
		check("conv_done", conv_done, 1'b1);
		res = conv_data;
		cyc(2);
		conv_data = ~conv_data;
		check("sleep", {sleep_active, conv_active}, 2'b10);
	endtask
	task automatic t_reset();
		int k;
		cyc(2);
		check("rst", {sdo_oe, sck_oe, conv_active}, 3'b001);
		mode_chk();
		i_adcsc_host.sel(1'b0);
		cyc(6);
		check("eoc_busy", {sdo_oe, sdo_out}, 2'b11);
		i_adcsc_host.sel(1'b1);
		cyc(6);
		check("sdo_z", sdo_oe, 1'b0);
		wait_done(k);
		$display("test reset done");
	endtask
	task automatic t_sleep();
		i_adcsc_host.sel(1'b0);
		cyc(6);
		check("wake", {sleep_active, sdo_oe, sdo_out}, 3'b010);
		i_adcsc_host.sel(1'b1);
		cyc(6);
		check("resleep", {sleep_active, sdo_oe}, 2'b10);
		$display("test sleep done");
	endtask
	task automatic t_read(input logic [7:0] w, input int n);
		logic [23:0] rx;
		logic [23:0] fx;
		int          k;
		int          len;
		fx = {2'b00, res, cur[3] ? 4'h1 : {cur[6:4], 1'b0}};
		i_adcsc_host.sel(1'b0);
		cyc(6);
		check("sdo_oe", sdo_oe, 1'b1);
		i_adcsc_host.xfer(w, n, rx);
		check("frame", rx >> (24 - n), fx >> (24 - n));
		cyc(5);
		if (n == 24) check("eoc_next", sdo_line, 1'b1);
		if (n >= 8 && w[7]) cur = {w[6:3], ((w[2:1] == 2'h3) ? cur[2:1] : w[2:1]), w[0]};
		i_adcsc_host.sel(1'b1);
		cyc(6);
		check("conv_run", {conv_active, sdo_oe}, 2'b10);
		mode_chk();
		len = (cur[0] & ~cur[3]) ? 320 : 640;
		wait_done(k);
		check("conv_len", k > len - 80 && k < len + 40, 1'b1);
		$display("test read %h done", w);
	endtask
	task automatic t_int();
		int k;
		i_adcsc_host.idle(1'b1);
		cyc(3);
		i_adcsc_host.sel(1'b0);
		cyc(8);
		check("int_mode", {sck_pullup_en, sck_oe, sck_out}, 3'b111);
		i_adcsc_host.sel(1'b1);
		cyc(6);
		check("int_off", {sck_oe, sleep_active}, 2'b01);
		i_adcsc_host.sel(1'b0);
		cyc(6450);
		check("int_frame", isk_rx, {2'b00, res, cur[3] ? 4'h1 : {cur[6:4], 1'b0}});
		check("int_end", {conv_active, sck_oe, sdo_oe, sdo_out}, 4'b1011);
		i_adcsc_host.sel(1'b1);
		cyc(6);
		wait_done(k);
		i_adcsc_host.idle(1'b0);
		cyc(3);
		i_adcsc_host.sel(1'b0);
		cyc(8);
		check("ext_mode", {sck_pullup_en, sck_oe}, 2'b00);
		i_adcsc_host.sel(1'b1);
		cyc(6);
		$display("test clock mode done");
	endtask
	task automatic t_ext();
		repeat (40) begin
			cyc(4);
			conv_clock_pin = ~conv_clock_pin;
		end
		check("ext_clk", conv_clock_ext, 1'b1);
		cyc(2100);
		check("osc_clk", conv_clock_ext, 1'b0);
		$display("test conversion clock done");
	endtask

	initial begin
		logic [15:0] tbl [9] = '{16'h0018, 16'h7018, 16'hf918, 16'h8218, 16'h8418,
			16'h8618, 16'hb005, 16'h900c, 16'h0018};
		sys_clk = 1'b0;
		reset = 1'b1;
		conv_clock_pin = 1'b0;
		conv_data = 18'h2a5c3;
		repeat (5) @(negedge sys_clk);
		reset = 1'b0;
		t_reset();
		t_sleep();
		for (int g = 0; g < 16; g++) t_read({1'b1, g[2:0], 3'b000, g[3]}, 24);
		t_int();
		t_ext();
		for (int i = 0; i < 9; i++) t_read(tbl[i][15:8], int'(tbl[i][7:0]));
		results();
	end
	initial begin
		#5000000;
		fails++;
		results();
	end
endmodule
